// [rtl/bisec_top.sv]
// Top: ISA alias blocking, error forwarding and capability identifier
//
// Functional notes
// [R1] ISA blocking stops downstream upper-768-byte I/O
// [R2] ISA blocking forwards upstream upper-768-byte I/O
// [R3] Blocking off: forward whole I/O window
// [R4] Control bits reset and warm-reset to zero
// [R5] Software avoids ISA blocking with mapping extensions
// [R6] Legacy: secondary SERR drives error pin
// [R7] Flood: secondary SERR floods both links
// [R8] Legacy: error response gates parity reporting
// [R9] Flood: master data error needs error response
// [R10] Flood: address parity error floods links
// [R11] Address parity error sets two status flags
// [R12] Target-aborted parity cycle sets abort flag
// [R13] Master data parity sets master data error
// [R14] Target data parity sets parity detected
// [R15] Data parity error marks outgoing packet
// [R16] Capability identifier reads constant at 40h
// [R17] Static mode selects legacy or flood
`timescale 1ns/100ps

module bisec_top
    import bisec_pkg::*;
(
    input  wire logic           i_core_clk,
    input  wire logic           i_arst_n,
    input  wire logic           i_warm_rst,
    input  wire bisec_mode_t    i_mode,
    input  wire logic           i_primary_serr_enable,
    input  wire logic [31:0]    i_io_base,
    input  wire logic [31:0]    i_io_limit,
    input  wire bisec_io_req_t  i_p2s_io,
    input  wire bisec_io_req_t  i_s2p_io,
    input  wire bisec_sec_err_t i_sec_err,
    input  wire bisec_avs_req_t i_avs,
    output logic                o_avs_waitrequest,
    output logic [31:0]         o_avs_readdata,
    output bisec_io_dec_t       o_p2s_dec,
    output bisec_io_dec_t       o_s2p_dec,
    output logic                o_fatal_error_pin_n,
    output logic                o_nonfatal_error_pin_n,
    output logic                o_primary_parity_error_pin_n,
    output logic                o_sync_flood,
    output logic                o_pkt_data_error,
    output logic                o_irq
);

    // State of the block, apart from the two reset release flops
    typedef struct packed {
        logic          waitreq;
        logic [31:0]   rdata;
        logic [2:0]    bctrl;
        logic [5:0]    evt;
        logic [5:0]    mask;
        bisec_io_dec_t p2s;
        bisec_io_dec_t s2p;
        logic          fatal_n;
        logic          nonfatal_n;
        logic          perr_n;
        logic          flood;
        logic          pkt_derr;
        logic          irq;
    } bisec_state_t;

    localparam bisec_state_t BISEC_ST_RESET = '{
        waitreq:    1'b1,
        rdata:      32'h0000_0000,
        bctrl:      BISEC_BC_RESET,
        evt:        BISEC_EV_RESET,
        mask:       BISEC_MASK_RESET,
        p2s:        2'h0,
        s2p:        2'h0,
        fatal_n:    1'b1,
        nonfatal_n: 1'b1,
        perr_n:     1'b1,
        flood:      1'b0,
        pkt_derr:   1'b0,
        irq:        1'b0
    };

    // Address inside the I/O base/limit window
    function automatic logic in_window(input logic [31:0] a,
                                       input logic [31:0] base,
                                       input logic [31:0] lim);
        in_window = (a >= base) && (a <= lim);
    endfunction : in_window

    // Upper 768 bytes of a 1K block within the first 64K
    function automatic logic isa_alias(input logic [31:0] a);
        isa_alias = (a[BISEC_ALIAS_HI:BISEC_ALIAS_LO] != 2'h0) &&
                    (a[31:BISEC_IO64K_BIT] == 16'h0000);
    endfunction : isa_alias

    // Expand byte enables to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    logic         rst_meta_n;
    logic         rst_n;
    bisec_state_t st;
    bisec_state_t next_st;

    logic        flood_mode;
    logic        err_resp;
    logic        serr_fwd;
    logic        isa_blk;
    logic [31:0] wmask;
    logic [5:0]  set_ev;
    logic [5:0]  clr_ev;
    logic        accept;
    logic        do_flood;
    logic        legacy_serr;
    logic        legacy_par;
    logic        data_perr;

    // Reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Next state
    always_comb
    begin
        next_st    = st;
        flood_mode = (i_mode == BISEC_FLOOD_SINGLE_LINK_MODE) ||
                     (i_mode == BISEC_FLOOD_DUAL_LINK_MODE);   // R17
        err_resp   = st.bctrl[BISEC_BC_ERR_RESP];
        serr_fwd   = st.bctrl[BISEC_BC_SERR_FWD];
        isa_blk    = st.bctrl[BISEC_BC_ISA_BLK];
        wmask      = be_mask(i_avs.byteenable);
        accept     = !st.waitreq;
        data_perr  = i_sec_err.data_perr_mst || i_sec_err.data_perr_tgt;

        // Avalon handshake: one wait cycle, then answer for one cycle
        next_st.waitreq = 1'b1;
        if ((i_avs.read || i_avs.write) && st.waitreq)
        begin
            next_st.waitreq = 1'b0;
            next_st.rdata   = 32'h0000_0000;
            if (i_avs.read)
            begin
                case (i_avs.address)
                    BISEC_OFS_BRIDGE_CTRL:
                        next_st.rdata = {29'h0, st.bctrl};
                    BISEC_OFS_CAP_ID:
                        next_st.rdata = {24'h0, BISEC_CAP_ID_VAL}; // R16
                    BISEC_OFS_EVT_STATUS:
                        next_st.rdata = {26'h0, st.evt};
                    BISEC_OFS_EVT_MASK:
                        next_st.rdata = {26'h0, st.mask};
                    BISEC_OFS_STATE:
                        next_st.rdata = {27'h0, st.flood, flood_mode,
                                         st.fatal_n, st.nonfatal_n,
                                         i_primary_serr_enable};
                    default:
                        next_st.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Write takes effect at the edge with waitrequest low
        clr_ev = 6'h00;
        if (accept && i_avs.write)
        begin
            case (i_avs.address)
                BISEC_OFS_BRIDGE_CTRL:
                    next_st.bctrl = (st.bctrl & ~wmask[2:0]) |
                                    (i_avs.writedata[2:0] & wmask[2:0]);
                BISEC_OFS_EVT_STATUS:
                    clr_ev = i_avs.writedata[5:0] & wmask[5:0];
                BISEC_OFS_EVT_MASK:
                    next_st.mask = (st.mask & ~wmask[5:0]) |
                                   (i_avs.writedata[5:0] & wmask[5:0]);
                default:
                    next_st.bctrl = st.bctrl;
            endcase
        end
        if (i_warm_rst)
        begin
            next_st.bctrl = BISEC_BC_RESET;                       // R4
        end

        // I/O forwarding decisions, one cycle after the request
        next_st.p2s.valid   = i_p2s_io.valid;
        next_st.p2s.forward = i_p2s_io.valid &&
            in_window(i_p2s_io.addr, i_io_base, i_io_limit) &&    // R3
            !(isa_blk && isa_alias(i_p2s_io.addr));               // R1
        next_st.s2p.valid   = i_s2p_io.valid;
        next_st.s2p.forward = i_s2p_io.valid &&
            (!in_window(i_s2p_io.addr, i_io_base, i_io_limit) ||
             (isa_blk && isa_alias(i_s2p_io.addr)));              // R2

        // Secondary error events into status flags
        set_ev = 6'h00;
        set_ev[BISEC_EV_SEC_SERR]    = i_sec_err.serr;
        set_ev[BISEC_EV_SEC_PAR_DET] = i_sec_err.addr_perr ||
                                       i_sec_err.data_perr_tgt;   // R11 R14
        set_ev[BISEC_EV_PRI_SERR_SIG] = i_sec_err.addr_perr;      // R11
        set_ev[BISEC_EV_SEC_SIG_TABT] = i_sec_err.addr_perr &&
                                        i_sec_err.addr_perr_tabt; // R12
        set_ev[BISEC_EV_SEC_MDATA_ERR] = i_sec_err.data_perr_mst &&
                                         err_resp;                // R9 R13

        // Flood conditions in the flood modes
        do_flood = flood_mode && i_primary_serr_enable &&
                   ((serr_fwd && i_sec_err.serr) ||               // R7
                    (err_resp && i_sec_err.addr_perr));           // R10
        set_ev[BISEC_EV_SYNC_FLOOD] = do_flood;
        if (do_flood)
        begin
            next_st.flood = 1'b1;
        end
        if (i_warm_rst)
        begin
            next_st.flood = 1'b0;
        end

        // Set wins over a clear in the same cycle
        next_st.evt = (st.evt & ~clr_ev) | set_ev;

        // Legacy sideband error pins
        legacy_serr = !flood_mode && serr_fwd && i_primary_serr_enable &&
                      st.evt[BISEC_EV_SEC_SERR];                  // R6
        legacy_par  = !flood_mode && err_resp &&
                      (st.evt[BISEC_EV_SEC_PAR_DET] ||
                       st.evt[BISEC_EV_SEC_MDATA_ERR]);           // R8
        next_st.fatal_n    = !legacy_serr;
        next_st.nonfatal_n = !legacy_par;
        next_st.perr_n     = !(!flood_mode && err_resp && data_perr); // R8

        // Data error bit on the outgoing packet
        next_st.pkt_derr = data_perr && err_resp;                 // R15

        // Interrupt from unmasked sticky flags
        next_st.irq = |(next_st.evt & next_st.mask);
    end

    // State register
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= BISEC_ST_RESET;                                 // R4
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign o_avs_waitrequest            = st.waitreq;
    assign o_avs_readdata               = st.rdata;
    assign o_p2s_dec                    = st.p2s;
    assign o_s2p_dec                    = st.s2p;
    assign o_fatal_error_pin_n          = st.fatal_n;
    assign o_nonfatal_error_pin_n       = st.nonfatal_n;
    assign o_primary_parity_error_pin_n = st.perr_n;
    assign o_sync_flood                 = st.flood;
    assign o_pkt_data_error             = st.pkt_derr;
    assign o_irq                        = st.irq;

endmodule : bisec_top

// [rtl/bisec_pkg.sv]
// Package: register map, fields, modes and carriers of the ISA/error block
package bisec_pkg;

    // Byte addresses of the registers
    localparam logic [7:0] BISEC_OFS_BRIDGE_CTRL = 8'h3c;
    localparam logic [7:0] BISEC_OFS_CAP_ID      = 8'h40;
    localparam logic [7:0] BISEC_OFS_EVT_STATUS  = 8'h80;
    localparam logic [7:0] BISEC_OFS_EVT_MASK    = 8'h84;
    localparam logic [7:0] BISEC_OFS_STATE       = 8'h88;

    // Bridge control field positions
    localparam int BISEC_BC_ERR_RESP = 0;
    localparam int BISEC_BC_SERR_FWD = 1;
    localparam int BISEC_BC_ISA_BLK  = 2;
    localparam logic [2:0] BISEC_BC_RESET    = 3'h0;
    localparam logic [7:0] BISEC_CAP_ID_VAL  = 8'h08;

    // Event status field positions, same layout in the mask
    localparam int BISEC_EV_SEC_SERR      = 0;
    localparam int BISEC_EV_SEC_PAR_DET   = 1;
    localparam int BISEC_EV_SEC_SIG_TABT  = 2;
    localparam int BISEC_EV_SEC_MDATA_ERR = 3;
    localparam int BISEC_EV_PRI_SERR_SIG  = 4;
    localparam int BISEC_EV_SYNC_FLOOD    = 5;
    localparam int BISEC_EV_W             = 6;
    localparam logic [5:0] BISEC_EV_RESET   = 6'h00;
    localparam logic [5:0] BISEC_MASK_RESET = 6'h00;

    // ISA alias decode
    localparam int BISEC_ALIAS_LO     = 8;   // Bits 9:8 nonzero: upper 768
    localparam int BISEC_ALIAS_HI     = 9;
    localparam int BISEC_IO64K_BIT    = 16;  // Bits above 15 zero: below 64K

    // Operating mode of the bridge, static
    typedef enum logic [1:0] {
        BISEC_LEGACY_SINGLE_LINK_MODE,
        BISEC_LEGACY_DUAL_LINK_MODE,
        BISEC_FLOOD_SINGLE_LINK_MODE,
        BISEC_FLOOD_DUAL_LINK_MODE
    } bisec_mode_t;

    // I/O access offered for a forwarding decision
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } bisec_io_req_t;

    // Forwarding decision
    typedef struct packed {
        logic valid;
        logic forward;
    } bisec_io_dec_t;

    // Secondary bus error events, one-cycle pulses
    typedef struct packed {
        logic serr;            // SERR# seen asserted
        logic addr_perr;       // Address parity error
        logic addr_perr_tabt;  // Claimed and ended with target abort
        logic data_perr_mst;   // Data parity error as master
        logic data_perr_tgt;   // Data parity error as target
    } bisec_sec_err_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } bisec_avs_req_t;

endpackage : bisec_pkg

// [dv/bisec_sec_bus_model.sv]
// Secondary bus model: one-cycle error events on command
`timescale 1ns/100ps
module bisec_sec_bus_model
    import bisec_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [2:0] i_kind,
    output bisec_sec_err_t  o_err
);
    // One pulse per command; the abort only rides on an address error
    always_ff @(posedge i_clk)
    begin
        o_err <= '0;
        if (i_go)
        begin
            o_err.serr           <= i_kind == 3'h0;
            o_err.addr_perr      <= i_kind == 3'h1 || i_kind == 3'h2;
            o_err.addr_perr_tabt <= i_kind == 3'h2;
            o_err.data_perr_mst  <= i_kind == 3'h3;
            o_err.data_perr_tgt  <= i_kind == 3'h4;
        end
    end
endmodule : bisec_sec_bus_model

// [dv/bisec_monitor.sv]
// Checker: port-level properties of the ISA and error block
`timescale 1ns/100ps
module bisec_monitor
    import bisec_pkg::*;
(
    input wire logic           i_core_clk,
    input wire logic           i_arst_n,
    input wire bisec_mode_t    i_mode,
    input wire logic           i_primary_serr_enable,
    input wire logic [31:0]    i_io_base,
    input wire logic [31:0]    i_io_limit,
    input wire bisec_io_req_t  i_p2s_io,
    input wire bisec_io_req_t  i_s2p_io,
    input wire bisec_sec_err_t i_sec_err,
    input wire bisec_avs_req_t i_avs,
    input wire logic           o_avs_waitrequest,
    input wire logic [31:0]    o_avs_readdata,
    input wire bisec_io_dec_t  o_p2s_dec,
    input wire bisec_io_dec_t  o_s2p_dec,
    input wire logic           o_primary_parity_error_pin_n,
    input wire logic           o_sync_flood,
    input wire logic           o_pkt_data_error
);
    // Window, mode and data error decode
    logic p_in, s_in, fl, derr;
    assign p_in = i_p2s_io.addr >= i_io_base && i_p2s_io.addr <= i_io_limit;
    assign s_in = i_s2p_io.addr >= i_io_base && i_s2p_io.addr <= i_io_limit;
    assign fl   = i_mode >= BISEC_FLOOD_SINGLE_LINK_MODE;
    assign derr = i_sec_err.data_perr_mst || i_sec_err.data_perr_tgt;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    AST_DEC_VALID: assert property (i_p2s_io.valid |=> o_p2s_dec.valid)
        else $error("downstream decision missing");
    AST_P2S_OUT: assert property (i_p2s_io.valid && !p_in |=>
        !o_p2s_dec.forward) else $error("forward outside window");
    AST_P2S_KEEP: assert property (i_p2s_io.valid && p_in &&
        (i_p2s_io.addr[9:8] == 2'h0 || i_p2s_io.addr[31:16] != 16'h0)
        |=> o_p2s_dec.forward) else $error("non-alias access blocked");
    AST_S2P_OUT: assert property (i_s2p_io.valid && !s_in |=>
        o_s2p_dec.forward) else $error("upstream access dropped");
    AST_PKT: assert property (o_pkt_data_error |-> $past(derr))
        else $error("packet error without data error");
    AST_PERR: assert property ($fell(o_primary_parity_error_pin_n) |->
        !fl && $past(derr || i_sec_err.addr_perr))
        else $error("parity pin without cause");
    AST_FLOOD: assert property ($rose(o_sync_flood) |-> fl &&
        i_primary_serr_enable && $past(i_sec_err.serr || i_sec_err.addr_perr))
        else $error("flood without cause");
    AST_NO_FLOOD: assert property (!fl |-> !o_sync_flood)
        else $error("flood in legacy mode");
    AST_WAIT: assert property ((i_avs.read || i_avs.write) &&
        o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer timing wrong");
    AST_CAP_ID: assert property (i_avs.read && o_avs_waitrequest &&
        i_avs.address == BISEC_OFS_CAP_ID |=>
        o_avs_readdata == {24'h0, BISEC_CAP_ID_VAL})
        else $error("identifier read wrong");
endmodule : bisec_monitor

bind bisec_top bisec_monitor i_bisec_monitor (
    .i_core_clk, .i_arst_n, .i_mode, .i_primary_serr_enable, .i_io_base,
    .i_io_limit, .i_p2s_io, .i_s2p_io, .i_sec_err, .i_avs,
    .o_avs_waitrequest, .o_avs_readdata, .o_p2s_dec, .o_s2p_dec,
    .o_primary_parity_error_pin_n, .o_sync_flood, .o_pkt_data_error
);

// [dv/tb_bridge_isa_error_control.sv]
// Testbench: registers, I/O forwarding and error paths
`timescale 1ns/100ps
module tb_bridge_isa_error_control;
    import bisec_pkg::*;
    logic           clk = 1'b0, arst_n = 1'b0, warm = 1'b0, go = 1'b0;
    logic           pse = 1'b1, wr, fat_n, nf_n, perr_n, flood, pkt, irq;
    logic [31:0]    base = 32'h2000, lim = 32'h13fff, q, a, rd;
    logic [2:0]     kind = 3'h0;
    bisec_mode_t    mode = BISEC_LEGACY_DUAL_LINK_MODE;
    bisec_io_req_t  p2s = '0, s2p = '0;
    bisec_avs_req_t avs = '0;
    bisec_sec_err_t err;
    bisec_io_dec_t  pd, sd;
    int             failures = 0, n_tests = 0, ev, isa, fm, c, k, er, sf, fl;

    always #20 clk = ~clk;

    bisec_sec_bus_model i_bisec_sec_bus_model (.i_clk(clk), .i_go(go),
        .i_kind(kind), .o_err(err));
    bisec_top i_bisec_top (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_warm_rst(warm), .i_mode(mode), .i_primary_serr_enable(pse),
        .i_io_base(base), .i_io_limit(lim), .i_p2s_io(p2s), .i_s2p_io(s2p),
        .i_sec_err(err), .i_avs(avs), .o_avs_waitrequest(wr),
        .o_avs_readdata(rd), .o_p2s_dec(pd), .o_s2p_dec(sd),
        .o_fatal_error_pin_n(fat_n), .o_nonfatal_error_pin_n(nf_n),
        .o_primary_parity_error_pin_n(perr_n), .o_sync_flood(flood),
        .o_pkt_data_error(pkt), .o_irq(irq));

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs <= '{read: !w, write: w, address: ad, byteenable: 4'hf,
                 writedata: d};
        @(posedge clk);
        while (wr !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        q = rd;
        if (n == 20)
        begin
            failures++;
            results();
        end
        avs.read <= 1'b0;
        avs.write <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(q, e);
    endtask : rdchk

    // Reference forwarding decisions
    function automatic logic fwd_p(input logic [31:0] x, input int b);
        return x >= base && x <= lim &&
            !(b != 0 && x < 32'h10000 && x[9:8] != 2'h0);
    endfunction : fwd_p

    function automatic logic fwd_s(input logic [31:0] x, input int b);
        return !(x >= base && x <= lim) || (b != 0 && x[9:8] != 2'h0);
    endfunction : fwd_s

    initial
    begin
        void'($urandom(90));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(BISEC_OFS_BRIDGE_CTRL, 32'h0);
        bus(1'b1, BISEC_OFS_CAP_ID, 32'hff);
        rdchk(BISEC_OFS_CAP_ID, 32'h8);
        rdchk(8'h10, 32'h0);
        rdchk(BISEC_OFS_EVT_MASK, 32'h0);
        $display("test registers done");
        for (isa = 1; isa >= 0; isa--)
        begin
            bus(1'b1, BISEC_OFS_BRIDGE_CTRL, 32'(isa * 4));
            rdchk(BISEC_OFS_BRIDGE_CTRL, 32'(isa * 4));
            repeat (60)
            begin
                @(posedge clk);
                a = $urandom & 32'h1ffff;
                p2s <= '{1'b1, a};
                s2p <= '{1'b1, a & 32'hffff};
                @(posedge clk);
                @(negedge clk);
                chk(pd.forward, fwd_p(a, isa));
                chk(sd.forward, fwd_s(a & 32'hffff, isa));
            end
        end
        p2s <= '0;
        s2p <= '0;
        $display("test forwarding done");
        for (fm = 0; fm < 2; fm++)
        begin
            if (fm == 1)
            begin
                arst_n <= 1'b0;
                mode <= BISEC_FLOOD_DUAL_LINK_MODE;
                repeat (4) @(posedge clk);
                arst_n <= 1'b1;
                repeat (3) @(posedge clk);
            end
            for (c = 0; c < 20; c++)
            begin
                k = c % 5;
                er = (c / 5) % 2;
                sf = c / 10;
                bus(1'b1, BISEC_OFS_BRIDGE_CTRL, 32'(er + 2 * sf));
                bus(1'b1, BISEC_OFS_EVT_MASK, er ? 32'h3f : 32'h0);
                fl = fm && ((k == 0 && sf) || ((k == 1 || k == 2) && er));
                ev = k == 0 ? 1 : k == 1 ? 18 : k == 2 ? 22 : k == 3 ? er * 8 : 2;
                ev += fl * 32;
                @(posedge clk);
                kind <= k[2:0];
                go <= 1'b1;
                @(posedge clk);
                go <= 1'b0;
                @(posedge clk);
                @(negedge clk);
                chk(pkt, k > 2 && er);
                if (k > 2)
                    chk(perr_n, !(fm == 0 && er));
                chk(flood, fl);
                repeat (2) @(negedge clk);
                chk(fat_n, !(fm == 0 && k == 0 && sf));
                chk(nf_n, !(fm == 0 && er && k > 0));
                chk(irq, ev != 0 && er);
                rdchk(BISEC_OFS_EVT_STATUS, ev);
                @(posedge clk);
                warm <= 1'b1;
                @(posedge clk);
                warm <= 1'b0;
                @(negedge clk);
                chk(flood, 0);
                rdchk(BISEC_OFS_BRIDGE_CTRL, 32'h0);
                bus(1'b1, BISEC_OFS_EVT_STATUS, 32'h3f);
                rdchk(BISEC_OFS_EVT_STATUS, 32'h0);
                chk(irq, 0);
            end
        end
        $display("test errors done");
        results();
    end
endmodule : tb_bridge_isa_error_control
